/* File: include/adc_pkg.sv */
// package: timing constants, pin widths and state types for the dram controller
package adc_pkg;
   // ***************************************
   // clock and pin widths
   // ***************************************
   localparam int unsigned CLK_NS       = 40;       // ref_clk_i period
   localparam int unsigned ADDR_W       = 11;       // mux_address width
   localparam int unsigned DATA_W       = 4;        // data_pins width
   localparam int unsigned ROW_W        = 11;       // row part of a word address
   localparam int unsigned COL_W        = 11;       // column part of a word address
   localparam int unsigned WORD_ADDR_W  = ROW_W + COL_W;
   // ***************************************
   // documented times, in their own units
   // ***************************************
   localparam int unsigned T_PAUSE_US   = 200;      // power-up pause
   localparam int unsigned T_REF_MS     = 32;       // refresh period
   localparam int unsigned REF_CYCLES   = 2048;     // refreshes per period
   localparam int unsigned INIT_REFS    = 8;        // refreshes after the pause
   localparam int unsigned T_RAS_MIN_NS = 65;       // row strobe low, test-mode figure
   localparam int unsigned T_RAS_MAX_NS = 10000;    // row strobe low, most
   localparam int unsigned T_RP_NS      = 40;       // row precharge
   localparam int unsigned T_RCD_NS     = 20;       // row to column strobe
   localparam int unsigned T_CAS_NS     = 20;       // column strobe low, test-mode figure
   localparam int unsigned T_CSR_NS     = 5;        // column before row set-up
   localparam int unsigned T_CHR_NS     = 10;       // column before row hold
   localparam int unsigned T_CPT_NS     = 20;       // counter test column precharge
   localparam int unsigned T_WTS_NS     = 10;       // write enable set-up, test entry
   localparam int unsigned T_WTH_NS     = 10;       // write enable hold, test entry
   // ***************************************
   // derived cycle counts (least rounds up, longest rounds down)
   // ***************************************
   function automatic int unsigned cyc_up(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int unsigned RAS_CYC  = cyc_up(T_RAS_MIN_NS);
   localparam int unsigned RAS_MAXC = T_RAS_MAX_NS / CLK_NS;
   localparam int unsigned RP_CYC   = cyc_up(T_RP_NS);
   localparam int unsigned RCD_CYC  = cyc_up(T_RCD_NS);
   localparam int unsigned CAS_CYC  = cyc_up(T_CAS_NS);
   localparam int unsigned CSR_CYC  = cyc_up(T_CSR_NS);
   localparam int unsigned CHR_CYC  = cyc_up(T_CHR_NS);
   localparam int unsigned CPT_CYC  = cyc_up(T_CPT_NS);
   localparam int unsigned WTS_CYC  = cyc_up(T_WTS_NS);
   localparam int unsigned WTH_CYC  = cyc_up(T_WTH_NS);
   localparam int unsigned PAUSE_CYC_DEF = T_PAUSE_US * 1000 / CLK_NS;
   // refresh spacing: period divided over the refresh count, rounded down
   localparam int unsigned REF_GAP_DEF = T_REF_MS * 1000000 / CLK_NS / REF_CYCLES;
   localparam int unsigned CNT_W = 16;             // width of the timing counter
   // ***************************************
   // state and command types
   // ***************************************
   typedef enum logic [1:0] {
      ADC_OP_READ, ADC_OP_WRITE, ADC_OP_TEST
   } adc_op_t;
   typedef enum {
      ADC_PAUSE, ADC_INIT, ADC_IDLE, ADC_ROW, ADC_COL, ADC_HOLD, ADC_PRE,
      ADC_CBR_SET, ADC_CBR_LOW, ADC_TM_SET, ADC_TM_HOLD
   } adc_state_t;
endpackage : adc_pkg

/* File: include/adc_tick_if.sv */
// interface: refresh-due handshake between the refresh timer and the sequencer
interface adc_tick_if;
   logic due;    // a refresh is owed
   logic taken;  // sequencer starts one refresh
   modport timer (output due, input taken);
   modport seq   (input due, output taken);
endinterface : adc_tick_if

/* File: hdl/adc_ref_timer.sv */
// refresh timer: paces refreshes so all rows are covered each period
module adc_ref_timer import adc_pkg::*; #(
   parameter int unsigned REF_GAP = REF_GAP_DEF
) (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic reset_i,
   // handshake toward the sequencer
   adc_tick_if.timer tick
);
   logic [CNT_W-1:0] gap;       // cycles since the last request
   logic [CNT_W-1:0] next_gap;
   logic [3:0]       owed;      // refreshes owed, saturating
   logic [3:0]       next_owed;
   // ***************************************
   // next value
   // ***************************************
   // owed refreshes are counted so a long access does not lose one
   always_comb begin
      next_gap  = gap + 16'h0001;
      next_owed = owed;
      if (gap >= CNT_W'(REF_GAP - 1)) begin
         next_gap = '0;
         if (owed != 4'hF) next_owed = owed + 4'h1;
      end
      if (tick.taken && next_owed != 4'h0) next_owed = next_owed - 4'h1;
   end
   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         gap  <= '0;
         owed <= 4'h0;
      end else begin
         gap  <= next_gap;
         owed <= next_owed;
      end
   end
   assign tick.due = (owed != 4'h0);
   // a refresh is requested at least once per spacing interval
   property p_ref_pace;
      @(posedge ref_clk_i) disable iff (reset_i)
      (gap == CNT_W'(REF_GAP - 1)) |=> (owed != 4'h0);
   endproperty
   a_ref_pace: assert property (p_ref_pace) else $error("refresh not owed");
endmodule : adc_ref_timer

/* File: hdl/adc_dram_ctrl.sv */
// dram controller: drives strobes, address and data of a multiplexed dynamic memory
module adc_dram_ctrl import adc_pkg::*; #(
   parameter int unsigned PAUSE_CYC = PAUSE_CYC_DEF,
   parameter int unsigned REF_GAP   = REF_GAP_DEF
) (
   // clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   reset_i,
   // user request
   input  wire logic                   req_i,
   input  wire logic [1:0]             req_op_i,
   input  wire logic [WORD_ADDR_W-1:0] req_addr_i,
   input  wire logic [DATA_W-1:0]      req_wdata_i,
   output logic                        req_ready_o,
   output logic                        rd_valid_o,
   output logic [DATA_W-1:0]           rd_data_o,
   output logic                        init_done_o,
   output logic                        test_mode_o,
   // memory pins
   output logic                        ras_n_o,
   output logic                        cas_n_o,
   output logic                        we_n_o,
   output logic                        oe_n_o,
   output logic [ADDR_W-1:0]           mux_address_o,
   input  wire logic [DATA_W-1:0]      data_pins_i,
   output logic [DATA_W-1:0]           data_pins_o,
   output logic                        data_pins_oe_o
);
   adc_tick_if tick ();
   adc_ref_timer #(.REF_GAP(REF_GAP)) u_timer (
      .ref_clk_i (ref_clk_i),
      .reset_i   (reset_i),
      .tick      (tick.timer)
   );
   adc_state_t           st, next_st;            // sequencer state
   logic [CNT_W-1:0]     cnt, next_cnt;          // cycles in the current state
   logic [3:0]           nref, next_nref;        // initial refreshes done
   adc_op_t              op, next_op;            // latched operation
   logic [WORD_ADDR_W-1:0] addr, next_addr;      // latched address
   logic [DATA_W-1:0]    wdat, next_wdat;        // latched write data
   logic                 ras_n, next_ras_n;
   logic                 cas_n, next_cas_n;
   logic                 we_n, next_we_n;
   logic                 oe_n, next_oe_n;
   logic [ADDR_W-1:0]    ma, next_ma;
   logic                 doe, next_doe;
   logic                 rdy, next_rdy;
   logic                 rv, next_rv;
   logic [DATA_W-1:0]    rd, next_rd;
   logic                 init, next_init;
   logic                 tm, next_tm;
   logic                 take;
   // ***************************************
   // sequencer next value
   // ***************************************
   // every timed state waits until cnt reaches its count then moves on;
   // the test-mode figures are used always, so entering test mode needs
   // no retiming of later cycles
   always_comb begin
      next_st = st; next_cnt = cnt + 16'h0001; next_nref = nref;
      next_op = op; next_addr = addr; next_wdat = wdat;
      next_ras_n = ras_n; next_cas_n = cas_n; next_we_n = we_n; next_oe_n = oe_n;
      next_ma = ma; next_doe = doe; next_rdy = 1'b0; next_rv = 1'b0;
      next_rd = rd; next_init = init; next_tm = tm; take = 1'b0;
      case (st)
         ADC_PAUSE: begin
            if (cnt >= CNT_W'(PAUSE_CYC - 1)) begin
               next_st = ADC_CBR_SET; next_cnt = '0; next_cas_n = 1'b0;
            end
         end
         ADC_INIT: begin
            // counter refreshes suit initialisation with the internal counter
            next_cnt = '0;
            if (nref >= 4'(INIT_REFS)) begin
               next_st = ADC_IDLE; next_init = 1'b1; next_rdy = 1'b1;
            end else begin
               next_st = ADC_CBR_SET; next_cas_n = 1'b0;
            end
         end
         ADC_IDLE: begin
            next_cnt = '0; next_rdy = 1'b1;
            if (tick.due) begin
               take = 1'b1; next_rdy = 1'b0; next_st = ADC_CBR_SET; next_cas_n = 1'b0;
            end else if (req_i) begin
               next_rdy = 1'b0; next_op = adc_op_t'(req_op_i);
               next_addr = req_addr_i; next_wdat = req_wdata_i;
               next_ma = req_addr_i[WORD_ADDR_W-1 -: ROW_W];
               // test entry puts write enable low ahead of the row strobe
               if (adc_op_t'(req_op_i) == ADC_OP_TEST) begin
                  next_st = ADC_TM_SET; next_we_n = 1'b0; next_cas_n = 1'b0;
               end else next_st = ADC_ROW;
            end
         end
         ADC_ROW: begin
            next_ras_n = 1'b0; next_st = ADC_COL; next_cnt = '0;
         end
         ADC_COL: begin
            // column strobe comes after the minimum delay; later it would only
            // move the access onto the column path
            if (cnt >= CNT_W'(RCD_CYC - 1)) begin
               next_ma = addr[COL_W-1:0]; next_cnt = '0; next_st = ADC_HOLD;
               if (op == ADC_OP_WRITE) begin
                  // write enable and data settle a cycle before column fall
                  next_we_n = 1'b0; next_doe = 1'b1;
               end else next_oe_n = 1'b0;
            end
         end
         ADC_HOLD: begin
            if (cnt == '0) next_cas_n = 1'b0;
            if (cnt >= CNT_W'(CAS_CYC + 1) && cnt >= CNT_W'(RAS_CYC - RCD_CYC)) begin
               if (op == ADC_OP_READ) begin
                  next_rv = 1'b1; next_rd = data_pins_i;
               end
               next_ras_n = 1'b1; next_cas_n = 1'b1; next_we_n = 1'b1;
               next_oe_n = 1'b1; next_doe = 1'b0; next_cnt = '0; next_st = ADC_PRE;
            end
         end
         ADC_PRE: begin
            if (cnt >= CNT_W'(RP_CYC + CPT_CYC - 1)) begin
               next_cnt = '0;
               next_st = init ? ADC_IDLE : ADC_INIT;
               next_rdy = init && !tick.due;
            end
         end
         ADC_CBR_SET: begin
            // column was lowered last cycle; address pins are left alone
            if (cnt >= CNT_W'(CSR_CYC - 1)) begin
               next_ras_n = 1'b0; next_cnt = '0; next_st = ADC_CBR_LOW;
            end
         end
         ADC_CBR_LOW: begin
            if (cnt == CNT_W'(CHR_CYC)) next_cas_n = 1'b1;
            if (cnt >= CNT_W'(RAS_CYC - 1) && cnt >= CNT_W'(CHR_CYC)) begin
               next_ras_n = 1'b1; next_cas_n = 1'b1; next_cnt = '0; next_st = ADC_PRE;
               if (!init) next_nref = nref + 4'h1;
            end
         end
         ADC_TM_SET: begin
            if (cnt >= CNT_W'(WTS_CYC - 1)) begin
               next_ras_n = 1'b0; next_cnt = '0; next_st = ADC_TM_HOLD;
            end
         end
         ADC_TM_HOLD: begin
            if (cnt >= CNT_W'(WTH_CYC)) next_we_n = 1'b1;
            if (cnt >= CNT_W'(RAS_CYC - 1) && cnt > CNT_W'(WTH_CYC)) begin
               next_ras_n = 1'b1; next_cas_n = 1'b1; next_tm = 1'b1;
               next_cnt = '0; next_st = ADC_PRE;
            end
         end
         default: begin
            next_st = ADC_PAUSE; next_cnt = '0;
         end
      endcase
   end
   assign tick.taken = take;
   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         st <= ADC_PAUSE; cnt <= '0; nref <= 4'h0; op <= ADC_OP_READ;
         addr <= '0; wdat <= '0; ras_n <= 1'b1; cas_n <= 1'b1; we_n <= 1'b1;
         oe_n <= 1'b1; ma <= '0; doe <= 1'b0; rdy <= 1'b0; rv <= 1'b0;
         rd <= '0; init <= 1'b0; tm <= 1'b0;
      end else begin
         st <= next_st; cnt <= next_cnt; nref <= next_nref; op <= next_op;
         addr <= next_addr; wdat <= next_wdat; ras_n <= next_ras_n;
         cas_n <= next_cas_n; we_n <= next_we_n; oe_n <= next_oe_n; ma <= next_ma;
         doe <= next_doe; rdy <= next_rdy; rv <= next_rv; rd <= next_rd;
         init <= next_init; tm <= next_tm;
      end
   end
   assign ras_n_o = ras_n; assign cas_n_o = cas_n; assign we_n_o = we_n;
   assign oe_n_o = oe_n; assign mux_address_o = ma; assign data_pins_o = wdat;
   assign data_pins_oe_o = doe; assign req_ready_o = rdy; assign rd_valid_o = rv;
   assign rd_data_o = rd; assign init_done_o = init; assign test_mode_o = tm;
   // ***************************************
   // checks
   // ***************************************
   logic [CNT_W-1:0] ras_low;  // cycles with row strobe low
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) ras_low <= '0;
      else ras_low <= ras_n ? '0 : ras_low + 16'h0001;
   end
   property p_ras_max;
      @(posedge ref_clk_i) disable iff (reset_i) ras_low <= CNT_W'(RAS_MAXC);
   endproperty
   a_ras_max: assert property (p_ras_max) else $error("row strobe low too long");
   property p_early_we;
      @(posedge ref_clk_i) disable iff (reset_i)
      ($fell(cas_n) && !ras_n && op == ADC_OP_WRITE) |-> ($past(!we_n) && doe);
   endproperty
   a_early_we: assert property (p_early_we) else $error("write enable late");
   // column already low one edge before the row fall and still low one edge after
   sequence s_cas_held;
      $past(!cas_n) ##1 !cas_n;
   endsequence
   property p_cbr_order;
      @(posedge ref_clk_i) disable iff (reset_i)
      ($fell(ras_n) && !cas_n) |-> s_cas_held;
   endproperty
   a_cbr_order: assert property (p_cbr_order) else $error("cbr order broken");
   property p_init_gate;
      @(posedge ref_clk_i) disable iff (reset_i) rdy |-> (nref >= 4'(INIT_REFS));
   endproperty
   a_init_gate: assert property (p_init_gate) else $error("access before init");
   property p_rd_oe;
      @(posedge ref_clk_i) disable iff (reset_i) doe |-> oe_n;
   endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("bus fight");
endmodule : adc_dram_ctrl

/* File: sim/adc_dram_model.sv */
// memory model: behavioural multiplexed dynamic memory facing the controller
module adc_dram_model import adc_pkg::*; (
   // strobes and address
   input  wire logic              ras_n_i,
   input  wire logic              cas_n_i,
   input  wire logic              we_n_i,
   input  wire logic              oe_n_i,
   input  wire logic [ADDR_W-1:0] mux_address_i,
   // data pins
   input  wire logic [DATA_W-1:0] data_pins_i,
   output logic      [DATA_W-1:0] data_pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************
   // storage and statistics
   // ***************************************
   logic [DATA_W-1:0] cells [logic [WORD_ADDR_W-1:0]]; // written words
   logic [ROW_W-1:0]  row;                              // latched row
   logic [ROW_W-1:0]  ref_row = '0;                     // internal refresh counter
   logic [DATA_W-1:0] rd_word = '0;                     // word being read
   logic [DATA_W-1:0] last = '0;                        // last driven value
   logic              reading = 1'b0;                   // outputs enabled
   logic              in_cbr = 1'b0;                    // counter refresh running
   int                cbr_cnt = 0, acc_cnt = 0, rmw_cnt = 0, tm_cnt = 0;
   realtime           t_ras = 0, t_cas = 0, t_we = 0;
   realtime           t_col = 0, t_acc = 0, t_cas_up = 0, t_hold = 0;
   // access figures of test mode, which the controller applies to every cycle
   localparam realtime T_RAC = 65.0;                    // from row strobe fall
   localparam realtime T_CAC = 20.0;                    // from column strobe fall
   localparam realtime T_AA  = 35.0;                    // from column address change
   realtime           ras_max = 0, csr_min = 1.0e9, chr_min = 1.0e9, wts_min = 1.0e9;
   // ***************************************
   // row strobe fall: row latch or counter refresh
   // ***************************************
   always @(negedge ras_n_i) begin
      t_ras = $realtime;
      if (cas_n_i === 1'b0) begin
         // address pins ignored, counter used and advanced
         in_cbr = 1'b1;
         ref_row = ref_row + 1'b1;
         cbr_cnt++;
         if (t_ras - t_cas < csr_min) csr_min = t_ras - t_cas;
         if (we_n_i === 1'b0) begin
            tm_cnt++;
            if (t_ras - t_we < wts_min) wts_min = t_ras - t_we;
         end
      end else begin
         row = mux_address_i;
      end
   end
   // row strobe rise: longest low time
   always @(posedge ras_n_i) begin
      if ($realtime - t_ras > ras_max) ras_max = $realtime - t_ras;
      // column rising in this same step may be seen before or after us
      if (in_cbr) begin
         t_hold = (cas_n_i === 1'b0 || t_cas_up < t_ras) ? $realtime : t_cas_up;
         if (t_hold - t_ras < chr_min) chr_min = t_hold - t_ras;
      end
      in_cbr = 1'b0;
   end
   // column address change starts the address access path
   always @(mux_address_i) t_col = $realtime;
   // column strobe fall: early write captures here, else a read starts
   always @(negedge cas_n_i) begin
      t_cas = $realtime;
      if (ras_n_i === 1'b0) begin
         acc_cnt++;
         if (we_n_i === 1'b0) begin
            cells[{row, mux_address_i}] = data_pins_i;
         end else begin
            rd_word = cells.exists({row, mux_address_i}) ?
                      cells[{row, mux_address_i}] : ~mux_address_i[DATA_W-1:0];
            // data valid after the slowest of the three access paths
            t_acc = t_ras + T_RAC;
            if (t_cas + T_CAC > t_acc) t_acc = t_cas + T_CAC;
            if (t_col + T_AA > t_acc) t_acc = t_col + T_AA;
            reading <= #(t_acc - $realtime) 1'b1;
         end
      end
   end
   // column rise ends drive; hold time of a counter refresh measured
   always @(posedge cas_n_i) begin
      t_cas_up = $realtime;
      reading <= #1ns 1'b0;
   end
   // write enable falling late in a read would make a modify cycle
   always @(negedge we_n_i) begin
      t_we = $realtime;
      if (reading) rmw_cnt++;
   end
   // released pins show the inverse of the last value, never a copy
   always @* begin
      if (reading && oe_n_i === 1'b0) begin
         data_pins_o = rd_word;
         last = rd_word;
      end else begin
         data_pins_o = ~last;
      end
   end
endmodule // adc_dram_model

/* File: sim/async_dram_cycle_rules_tb_top.sv */
// testbench: controller against the memory model, scenario tasks and verdict
module async_dram_cycle_rules_tb_top import adc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ***************************************
   // signals
   // ***************************************
   localparam int unsigned GAP = 40;           // shortened refresh spacing
   logic                   ref_clk_i = 1'b0;
   logic                   reset_i = 1'b1;
   logic                   req_i = 1'b0;
   logic [1:0]             req_op_i = 2'h0;
   logic [WORD_ADDR_W-1:0] req_addr_i = '0;
   logic [DATA_W-1:0]      req_wdata_i = '0;
   logic                   req_ready_o, rd_valid_o, init_done_o, test_mode_o;
   logic [DATA_W-1:0]      rd_data_o, pins_out, pins_in;
   logic                   ras_n, cas_n, we_n, oe_n, pins_oe;
   logic [ADDR_W-1:0]      mux_address;
   int                     fail_count = 0, checked = 0;
   // clock at 25 MHz
   always #20 ref_clk_i = ~ref_clk_i;
   // ***************************************
   // design and memory model
   // ***************************************
   adc_dram_ctrl #(.PAUSE_CYC(10), .REF_GAP(GAP)) uut (
      .ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i), .req_op_i(req_op_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o),
      .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .init_done_o(init_done_o),
      .test_mode_o(test_mode_o), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
      .oe_n_o(oe_n), .mux_address_o(mux_address), .data_pins_i(pins_in),
      .data_pins_o(pins_out), .data_pins_oe_o(pins_oe));
   adc_dram_model mem (
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .oe_n_i(oe_n),
      .mux_address_i(mux_address), .data_pins_i(pins_out), .data_pins_o(pins_in));
   // ***************************************
   // shared tasks
   // ***************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // one request held until the memory shows it started, or until test_mode_o is set for a test request (bounded wait)
   task automatic do_req(input logic [1:0] op, input logic [WORD_ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      int n;
      int acc0;
      acc0 = mem.acc_cnt;
      q = 'x;
      @(negedge ref_clk_i);
      req_i = 1'b1; req_op_i = op; req_addr_i = a; req_wdata_i = d;
      n = 0;
      while (n < 400 && ((op == 2'h2) ? test_mode_o !== 1'b1 : mem.acc_cnt == acc0)) begin
         @(negedge ref_clk_i);
         n++;
      end
      @(negedge ref_clk_i);
      req_i = 1'b0;
      if (op == 2'h0) begin
         // outputs looked at mid-cycle, well away from the edge that launches them
         while (n < 400 && rd_valid_o !== 1'b1) begin
            @(negedge ref_clk_i);
            n++;
         end
         q = rd_data_o;
         @(negedge ref_clk_i);
         chk(rd_valid_o, 0);
      end
      chk(n < 400, 1);
      repeat (4) @(negedge ref_clk_i);
   endtask
   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_init();
      int n;
      n = 0;
      while (n < 2000 && init_done_o !== 1'b1) begin
         @(negedge ref_clk_i);
         n++;
      end
      chk(n >= 10, 1);
      chk(req_ready_o, 1);
      chk(mem.cbr_cnt, 8);
      chk(mem.acc_cnt, 0);
   endtask
   task automatic t_wr_rd(input logic [WORD_ADDR_W-1:0] a[3]);
      logic [DATA_W-1:0] q;
      int rmw0;
      rmw0 = mem.rmw_cnt;
      foreach (a[i]) do_req(2'h1, a[i], DATA_W'(i + 4'h9), q);
      foreach (a[i]) chk(mem.cells[a[i]], DATA_W'(i + 4'h9));
      chk(pins_oe, 0);
      foreach (a[i]) begin
         do_req(2'h0, a[i], 4'h0, q);
         chk(q, DATA_W'(i + 4'h9));
      end
      do_req(2'h0, 22'h0007A3, 4'h0, q);
      chk(q, 4'hC);
      chk(mem.rmw_cnt, rmw0);
   endtask
   task automatic t_pace();
      int c0;
      int d;
      c0 = mem.cbr_cnt;
      repeat (20 * GAP) @(posedge ref_clk_i);
      d = mem.cbr_cnt - c0;
      chk(d >= 19 && d <= 21, 1);
      chk(mem.csr_min >= 5.0 && mem.chr_min >= 10.0, 1);
      chk(mem.ras_max <= 10000.0, 1);
   endtask
   task automatic t_test_mode();
      logic [DATA_W-1:0] q;
      do_req(2'h2, '0, 4'h0, q);
      chk(test_mode_o, 1);
      chk(mem.tm_cnt >= 1 && mem.wts_min >= 10.0, 1);
      do_req(2'h1, 22'h2AAAAA, 4'h5, q);
      do_req(2'h0, 22'h2AAAAA, 4'h0, q);
      chk(q, 4'h5);
   endtask
   // ***************************************
   // main sequence and watchdog
   // ***************************************
   initial begin
      repeat (10) @(negedge ref_clk_i);
      reset_i = 1'b0;
      t_init();
      t_wr_rd('{22'h3FFFFF, 22'h000000, 22'h3FF800});
      t_pace();
      t_test_mode();
      complete_run();
   end
   initial begin
      #(40 * 20000);
      fail_count++;
      complete_run();
   end
endmodule // async_dram_cycle_rules_tb_top
